//--- rtl/tdxc_regs.vh
// Register offsets, field positions and reset values for the de-alias and
// crosstalk calibration register slice. Definitions only.
`ifndef TDXC_REGS_VH
`define TDXC_REGS_VH

// Register addresses (8-bit register index of the control interface)
`define TDXC_ADDR_XTALK_I 8'h3D
`define TDXC_ADDR_XTALK_Q 8'h3E
`define TDXC_ADDR_CAL_CH2_LOW 8'h3F
`define TDXC_ADDR_DEALIAS_CTRL 8'h40
`define TDXC_ADDR_ILLUM_SCALE 8'h41
`define TDXC_ADDR_PHASE_OFS 8'h42

// Field positions
`define TDXC_LOW16_MSB 15
`define TDXC_TEMP_HI_MSB 23
`define TDXC_TEMP_HI_LSB 12
`define TDXC_TEMP_LO_MSB 11
`define TDXC_RSVD_TOP_BIT 23
`define TDXC_TWO_FREQ_BIT 22
`define TDXC_SECOND_FREQ_BIT 21
`define TDXC_INT_BETA_MSB 20
`define TDXC_INT_BETA_LSB 15
`define TDXC_INT_ALPHA_MSB 14
`define TDXC_INT_ALPHA_LSB 9
`define TDXC_RSVD_MID_MSB 8
`define TDXC_RSVD_MID_LSB 1
`define TDXC_DEALIAS_EN_BIT 0
`define TDXC_ILL_BETA_MSB 11
`define TDXC_ILL_BETA_LSB 6
`define TDXC_ILL_ALPHA_MSB 5
`define TDXC_ILL_ALPHA_LSB 0

// Reset values
`define TDXC_RST_ZERO 24'h00_0000
`define TDXC_RST_DEALIAS_CTRL 24'h20_21E0
`define TDXC_RST_ILLUM_SCALE 24'h00_0010
`define TDXC_RST_RSVD_MID 8'hF0

`endif

//--- rtl/tdxc_calib_regs.v
// De-alias control and crosstalk calibration register slice (3Dh..42h).
// Assumes the control-interface front end presents decoded, same-clock
// 24-bit register write strobes and read addresses.
//
// How it works
// - Register 3Dh holds a 16-bit writable internal crosstalk in-phase value, upper byte reads 0.
// - Register 3Eh holds a 16-bit writable internal crosstalk quadrature value, upper byte reads 0.
// - Register 3Fh bits 23:12 hold the external sensor calibration temperature, channel 2 low.
// - Register 3Fh bits 11:0 hold the on-chip sensor calibration temperature, channel 2 low.
// - Register 41h bits 23:12 hold the on-chip sensor calibration temperature, channel 1 high.
// - Two-frequency phase reporting is on only when both 40h bit 22 and the de-alias enable are 1.
// - While two-frequency reporting runs, a flag shows which frequency the phase belongs to.
// - Register 40h bit 21 picks the second frequency, 0 for 10x6/7 and 1 for 10x6/5 MHz.
// - Register 40h bits 20:15 and 14:9 give internal crosstalk beta and alpha in sixteenths.
// - Register 41h bits 11:6 and 5:0 give illumination crosstalk beta and alpha in sixteenths.
// - Register 40h bit 0 selects de-alias measurement mode, reset 0.
// - Register 42h bits 15:0 hold a 16-bit phase offset for channel 0 low, upper byte reserved.
`timescale 1ns/1ps
`default_nettype none
`include "tdxc_regs.vh"

module tdxc_calib_regs (
   // Clock and reset
   input wire i_ref_clk,
   input wire i_srst,
   // Register access from the control interface
   input wire i_wr_en,
   input wire [7:0] i_wr_addr,
   input wire [23:0] i_wr_data,
   input wire [7:0] i_rd_addr,
   output reg [23:0] o_rd_data,
   output reg o_rd_hit,
   // Frame timing from the phase datapath
   input wire i_frame_done,
   // Fields to the phase datapath
   output reg [15:0] o_internal_xtalk_i,
   output reg [15:0] o_internal_xtalk_q,
   output reg [11:0] o_ext_sensor_cal_temp_ch2_low,
   output reg [11:0] o_chip_sensor_cal_temp_ch2_low,
   output reg [11:0] o_chip_sensor_cal_temp_ch1_high,
   output reg [15:0] o_phase_offset_ch0_low,
   output reg [5:0] o_internal_xtalk_beta,
   output reg [5:0] o_internal_xtalk_alpha,
   output reg [5:0] o_illum_xtalk_beta,
   output reg [5:0] o_illum_xtalk_alpha,
   output reg o_dealias_measure_enable,
   output reg o_second_freq_select,
   output reg o_two_freq_active,
   output reg o_mod_frequency_flag
);

   // Stored register words; reserved bits are kept as storage where writable
   reg [23:0] xtalk_i;
   reg [23:0] xtalk_q;
   reg [23:0] cal_ch2_low;
   reg [23:0] dealias_ctrl;
   reg [23:0] illum_scale;
   reg [23:0] phase_ofs;
   reg two_freq_phase_enable;

   wire next_two_freq_active;
   wire [23:0] zero_word;

   assign zero_word = `TDXC_RST_ZERO;

   // Each register only changes on a write to its own address
   always @(posedge i_ref_clk) begin
      if (i_srst) begin
         xtalk_i <= `TDXC_RST_ZERO;
         xtalk_q <= `TDXC_RST_ZERO;
         cal_ch2_low <= `TDXC_RST_ZERO;
         dealias_ctrl <= `TDXC_RST_DEALIAS_CTRL;
         illum_scale <= `TDXC_RST_ILLUM_SCALE;
         phase_ofs <= `TDXC_RST_ZERO;
      end else if (i_wr_en) begin
         case (i_wr_addr)
            `TDXC_ADDR_XTALK_I: begin
               // Upper byte is read-only zero
               xtalk_i <= {8'h00, i_wr_data[`TDXC_LOW16_MSB:0]};
            end
            `TDXC_ADDR_XTALK_Q: begin
               xtalk_q <= {8'h00, i_wr_data[`TDXC_LOW16_MSB:0]};
            end
            `TDXC_ADDR_CAL_CH2_LOW: begin
               cal_ch2_low <= i_wr_data;
            end
            `TDXC_ADDR_DEALIAS_CTRL: begin
               // Reserved bits stored as written; software keeps them at F0h/0
               dealias_ctrl <= i_wr_data;
            end
            `TDXC_ADDR_ILLUM_SCALE: begin
               illum_scale <= i_wr_data;
            end
            `TDXC_ADDR_PHASE_OFS: begin
               // Reserved upper byte is writable storage, like its neighbours
               phase_ofs <= i_wr_data;
            end
            default: begin
               xtalk_i <= xtalk_i;
            end
         endcase
      end
   end

   // Read-back mux, registered; unmapped addresses read zero with no hit
   always @(posedge i_ref_clk) begin
      if (i_srst) begin
         o_rd_data <= `TDXC_RST_ZERO;
         o_rd_hit <= 1'b0;
      end else begin
         o_rd_hit <= 1'b1;
         case (i_rd_addr)
            `TDXC_ADDR_XTALK_I: o_rd_data <= xtalk_i;
            `TDXC_ADDR_XTALK_Q: o_rd_data <= xtalk_q;
            `TDXC_ADDR_CAL_CH2_LOW: o_rd_data <= cal_ch2_low;
            `TDXC_ADDR_DEALIAS_CTRL: o_rd_data <= dealias_ctrl;
            `TDXC_ADDR_ILLUM_SCALE: o_rd_data <= illum_scale;
            `TDXC_ADDR_PHASE_OFS: o_rd_data <= phase_ofs;
            default: begin
               o_rd_data <= zero_word;
               o_rd_hit <= 1'b0;
            end
         endcase
      end
   end

   // Field outputs, one flop stage behind storage so outputs come from flops
   always @(posedge i_ref_clk) begin
      if (i_srst) begin
         o_internal_xtalk_i <= 16'h0000;
         o_internal_xtalk_q <= 16'h0000;
         o_ext_sensor_cal_temp_ch2_low <= 12'h000;
         o_chip_sensor_cal_temp_ch2_low <= 12'h000;
         o_chip_sensor_cal_temp_ch1_high <= 12'h000;
         o_phase_offset_ch0_low <= 16'h0000;
         o_internal_xtalk_beta <= 6'h00;
         o_internal_xtalk_alpha <= 6'h10;
         o_illum_xtalk_beta <= 6'h00;
         o_illum_xtalk_alpha <= 6'h10;
         o_dealias_measure_enable <= 1'b0;
         o_second_freq_select <= 1'b1;
         two_freq_phase_enable <= 1'b0;
      end else begin
         o_internal_xtalk_i <= xtalk_i[`TDXC_LOW16_MSB:0];
         o_internal_xtalk_q <= xtalk_q[`TDXC_LOW16_MSB:0];
         o_ext_sensor_cal_temp_ch2_low <= cal_ch2_low[`TDXC_TEMP_HI_MSB:`TDXC_TEMP_HI_LSB];
         o_chip_sensor_cal_temp_ch2_low <= cal_ch2_low[`TDXC_TEMP_LO_MSB:0];
         o_chip_sensor_cal_temp_ch1_high <= illum_scale[`TDXC_TEMP_HI_MSB:`TDXC_TEMP_HI_LSB];
         o_phase_offset_ch0_low <= phase_ofs[`TDXC_LOW16_MSB:0];
         // Scale codes pass raw; the datapath divides by 16 with a 4-bit shift
         o_internal_xtalk_beta <= dealias_ctrl[`TDXC_INT_BETA_MSB:`TDXC_INT_BETA_LSB];
         o_internal_xtalk_alpha <= dealias_ctrl[`TDXC_INT_ALPHA_MSB:`TDXC_INT_ALPHA_LSB];
         o_illum_xtalk_beta <= illum_scale[`TDXC_ILL_BETA_MSB:`TDXC_ILL_BETA_LSB];
         o_illum_xtalk_alpha <= illum_scale[`TDXC_ILL_ALPHA_MSB:`TDXC_ILL_ALPHA_LSB];
         o_dealias_measure_enable <= dealias_ctrl[`TDXC_DEALIAS_EN_BIT];
         o_second_freq_select <= dealias_ctrl[`TDXC_SECOND_FREQ_BIT];
         two_freq_phase_enable <= dealias_ctrl[`TDXC_TWO_FREQ_BIT];
      end
   end

   // Both enables needed; otherwise only the base frequency is reported
   assign next_two_freq_active = two_freq_phase_enable & o_dealias_measure_enable;

   // Frequency tag: toggles each finished frame while alternating,
   // held at base frequency (0) otherwise so a restart begins on 10 MHz
   always @(posedge i_ref_clk) begin
      if (i_srst) begin
         o_two_freq_active <= 1'b0;
         o_mod_frequency_flag <= 1'b0;
      end else begin
         o_two_freq_active <= next_two_freq_active;
         if (!next_two_freq_active) begin
            o_mod_frequency_flag <= 1'b0;
         end else if (i_frame_done) begin
            o_mod_frequency_flag <= ~o_mod_frequency_flag;
         end
      end
   end

endmodule // tdxc_calib_regs
`default_nettype wire

//--- bench/tdxc_calib_regs_chk.sv
// Assertions for the calibration register slice.
// Assumes bind onto tdxc_calib_regs; one clock, sync reset.
`timescale 1ns/1ps
`default_nettype none
module tdxc_calib_regs_chk (
   // Access side and observed outputs
   input wire logic i_ref_clk,
   input wire logic i_srst,
   input wire logic i_wr_en,
   input wire logic [7:0] i_wr_addr,
   input wire logic [23:0] i_wr_data,
   input wire logic [7:0] i_rd_addr,
   input wire logic i_frame_done,
   input wire logic [23:0] o_rd_data,
   input wire logic [5:0] o_internal_xtalk_alpha,
   input wire logic o_dealias_measure_enable,
   input wire logic o_second_freq_select,
   input wire logic o_two_freq_active,
   input wire logic o_mod_frequency_flag
);
   default clocking @(posedge i_ref_clk); endclocking
   default disable iff (i_srst);
   // Write strobe to one index
   sequence s_wr(a);
      i_wr_en && i_wr_addr == a;
   endsequence
   a_unmapped_zero: assert property (!(i_rd_addr inside {[8'h3D:8'h42]})
      |=> o_rd_data == 24'h00_0000) else $error("unmapped read");
   a_upper_byte_zero: assert property (i_rd_addr inside {8'h3D, 8'h3E}
      |=> o_rd_data[23:16] == 8'h00) else $error("upper byte set");
   a_write_readback: assert property (s_wr(8'h3F) ##1 (!i_wr_en && i_rd_addr == 8'h3F)
      |=> o_rd_data == $past(i_wr_data, 2)) else $error("readback");
   a_fields_follow: assert property (s_wr(8'h40) ##1 !i_wr_en
      |=> o_internal_xtalk_alpha == $past(i_wr_data[14:9], 2) && o_second_freq_select
      == $past(i_wr_data[21], 2) && o_dealias_measure_enable == $past(i_wr_data[0], 2))
      else $error("fields");
   // Reset must win, so this one is never disabled
   a_reset_values: assert property (@(posedge i_ref_clk) disable iff (1'b0) i_srst
      |=> o_internal_xtalk_alpha == 6'h10 && o_second_freq_select && !o_dealias_measure_enable
      && !o_two_freq_active && o_rd_data == 24'h00_0000) else $error("reset values");
   a_two_freq_off: assert property (!o_dealias_measure_enable [*2] |-> !o_two_freq_active)
      else $error("two freq");
   a_flag_idle: assert property (!o_two_freq_active [*2] |-> !o_mod_frequency_flag)
      else $error("flag idle");
   a_flag_toggle: assert property (o_two_freq_active ##1 (o_two_freq_active && i_frame_done)
      |=> o_mod_frequency_flag != $past(o_mod_frequency_flag)) else $error("flag toggle");
endmodule // tdxc_calib_regs_chk
bind tdxc_calib_regs tdxc_calib_regs_chk tdxc_calib_regs_chk_inst (.i_ref_clk, .i_srst,
   .i_wr_en, .i_wr_addr, .i_wr_data, .i_rd_addr, .i_frame_done, .o_rd_data,
   .o_internal_xtalk_alpha, .o_dealias_measure_enable, .o_second_freq_select,
   .o_two_freq_active, .o_mod_frequency_flag);
`default_nettype wire

//--- bench/tb_top.sv
// Self-checking bench for the calibration register slice.
// Assumes the slice alone, driven at its decoded access ports.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   // Stimulus, observed outputs, tables
   logic i_ref_clk = 1'b0, i_srst = 1'b1, i_wr_en = 1'b0, i_frame_done = 1'b0;
   logic [7:0] i_wr_addr = 8'h00, i_rd_addr = 8'h00;
   logic [23:0] i_wr_data = 24'h00_0000, rdat;
   logic [5:0] ia, la, ib, lb;
   logic hit, de, sf, tf, mf;
   logic [15:0] xi, xq, po;
   logic [11:0] et, ct, ch;
   int fail_count = 0, checks = 0;
   logic [23:0] wd [6] = '{24'hAB_1234, 24'hFF_8765, 24'hAB_CDEF,
      {2'b01, 1'b0, 6'h2A, 6'h15, 8'hF0, 1'b1}, {12'h9A5, 6'h2A, 6'h15}, 24'h00_5A5A};
   logic [23:0] rs [6] = '{24'h00_0000, 24'h00_0000, 24'h00_0000, 24'h20_21E0,
      24'h00_0010, 24'h00_0000};
   // 50 MHz clock
   always #10 i_ref_clk = ~i_ref_clk;
   tdxc_calib_regs tdxc_calib_regs_inst (.i_ref_clk, .i_srst, .i_wr_en, .i_wr_addr, .i_wr_data,
      .i_rd_addr, .o_rd_data(rdat), .o_rd_hit(hit), .i_frame_done, .o_internal_xtalk_i(xi),
      .o_internal_xtalk_q(xq), .o_ext_sensor_cal_temp_ch2_low(et),
      .o_chip_sensor_cal_temp_ch2_low(ct), .o_chip_sensor_cal_temp_ch1_high(ch),
      .o_phase_offset_ch0_low(po), .o_internal_xtalk_beta(ib),
      .o_internal_xtalk_alpha(ia), .o_illum_xtalk_beta(lb), .o_illum_xtalk_alpha(la),
      .o_dealias_measure_enable(de), .o_second_freq_select(sf), .o_two_freq_active(tf),
      .o_mod_frequency_flag(mf));
   // Compare and count
   task automatic cmp(input logic [23:0] got, input logic [23:0] exp);
      checks++;
      if (got !== exp) begin
         fail_count++;
         $display("BAD %0t got %h exp %h", $time, got, exp);
      end
   endtask
   // Write, leaving the same index on the read port for the next cycle
   task automatic wr(input logic [7:0] a, input logic [23:0] d);
      @(posedge i_ref_clk);
      i_wr_en <= 1'b1;
      i_wr_addr <= a;
      i_wr_data <= d;
      i_rd_addr <= a;
      @(posedge i_ref_clk);
      i_wr_en <= 1'b0;
   endtask
   // Read answer lands one edge after the index
   task automatic rd(input logic [7:0] a, input logic [23:0] e);
      @(posedge i_ref_clk);
      i_rd_addr <= a;
      @(posedge i_ref_clk);
      #1;
      cmp(rdat, e);
      cmp({23'h00_0000, hit}, {23'h00_0000, a >= 8'h3D && a <= 8'h42});
   endtask
   // One frame-end pulse
   task automatic frame;
      @(posedge i_ref_clk);
      i_frame_done <= 1'b1;
      @(posedge i_ref_clk);
      i_frame_done <= 1'b0;
      #1;
   endtask
   // Verdict and end of run
   task automatic complete_run;
      $display("checks %0d mismatches %0d", checks, fail_count);
      if (fail_count == 0 && checks > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask
   // Main sequence
   initial begin
      repeat (10) @(posedge i_ref_clk);
      i_srst <= 1'b0;
      for (int i = 0; i < 6; i++) rd(8'h3D + 8'(i), rs[i]);
      rd(8'h3C, 24'h00_0000);
      rd(8'h43, 24'h00_0000);
      cmp({ia, la, ib, lb}, 24'h41_0000);
      cmp({20'h0_0000, sf, de, tf, mf}, 24'h00_0008);
      cmp({xi, po[7:0]}, 24'h00_0000);
      cmp({et, ct}, 24'h00_0000);
      cmp({ch, xq[11:0]}, 24'h00_0000);
      $display("end test reset");
      for (int i = 0; i < 6; i++) wr(8'h3D + 8'(i), wd[i]);
      wr(8'h43, 24'hFF_FFFF);
      for (int i = 0; i < 6; i++) rd(8'h3D + 8'(i), i < 2 ? wd[i] & 24'h00_FFFF : wd[i]);
      cmp({1'b0, tf, sf, ib, ia, 8'hF0, de}, wd[3]);
      cmp({12'h000, lb, la}, 24'h00_0A95);
      cmp({8'h00, xi}, 24'h00_1234);
      cmp({8'h00, xq}, 24'h00_8765);
      cmp({et, ct}, 24'hAB_CDEF);
      cmp({12'h000, ch}, 24'h00_09A5);
      cmp({8'h00, po}, 24'h00_5A5A);
      $display("end test write");
      for (int k = 0; k < 3; k++) begin
         frame();
         cmp({23'h00_0000, mf}, {23'h00_0000, k % 2 == 0});
      end
      wr(8'h40, wd[3] & 24'hFF_FFFE);
      repeat (3) @(posedge i_ref_clk);
      frame();
      cmp({22'h00_0000, tf, mf}, 24'h00_0000);
      $display("end test flag");
      complete_run();
   end
   // Watchdog well past the run length
   initial begin
      #100us;
      fail_count++;
      $display("BAD %0t watchdog", $time);
      complete_run();
   end
endmodule // tb_top
`default_nettype wire
